// file: irq_enable_pkg.sv
/*
  Shared constants and types for the peripheral interrupt enable and mask block:
  register offsets, bit positions, implemented-bit masks, reset values and carriers.
  Assumes a single 20 MHz system clock and a plain one-cycle register port.
*/
// Summary of operation
// - No peripheral request reaches the core unless the peripheral group enable is set.
// - Enable register one bit 6 gates the conversion complete interrupt.
// - Enable register one bit 5 gates the serial receive buffer full interrupt.
// - Enable register one bit 4 gates the serial transmit buffer empty interrupt.
// - Enable register one bit 3 gates the synchronous serial port done interrupt.
// - Enable register one bit 2 gates the capture/compare unit interrupt.
// - Enable register one bit 1 gates the timer two period match interrupt.
// - Enable register one bit 0 gates the timer one overflow interrupt.
// - Enable register two bit 7 gates the oscillator failure interrupt.
// - Enable register two bit 6 gates the second comparator change interrupt.
// - Enable register two bit 5 gates the first comparator change interrupt.
// - Enable register two bit 4 gates the memory write complete interrupt.
// - Flags set on every event, whatever the enables hold.
// - Global enable passes unmasked interrupts when 1, suppresses all when 0.
// - Peripheral group enable passes unmasked peripheral interrupts when 1, else none.
package irq_enable_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_ENABLE_1 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_2 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_1 = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_2 = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 3'h5;

  // Group one layout
  localparam int CONV_DONE_BIT = 6;
  localparam int SERIAL_RX_FULL_BIT = 5;
  localparam int SERIAL_TX_EMPTY_BIT = 4;
  localparam int SYNC_SERIAL_DONE_BIT = 3;
  localparam int CAPTURE_COMPARE_BIT = 2;
  localparam int TIMER_TWO_MATCH_BIT = 1;
  localparam int TIMER_ONE_OVERFLOW_BIT = 0;
  // Group two layout
  localparam int OSC_FAIL_BIT = 7;
  localparam int COMPARATOR_TWO_BIT = 6;
  localparam int COMPARATOR_ONE_BIT = 5;
  localparam int NV_WRITE_DONE_BIT = 4;
  // Core control layout
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  // Pending summary layout
  localparam int PEND_GROUP_1_BIT = 0;
  localparam int PEND_GROUP_2_BIT = 1;
  localparam int PEND_REQUEST_BIT = 2;

  localparam logic [DATA_W-1:0] GROUP_1_IMPL_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] GROUP_2_IMPL_MASK = 8'hf0;
  localparam logic [DATA_W-1:0] CORE_CTRL_IMPL_MASK = 8'hc0;

  localparam logic [DATA_W-1:0] ENABLE_1_RST = 8'h00;
  localparam logic [DATA_W-1:0] ENABLE_2_RST = 8'h00;
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [DATA_W-1:0] CORE_CTRL_RST = 8'h00;

  // Event inputs from the peripherals, high for each cycle the condition holds
  typedef struct packed {
    logic conv_done;
    logic serial_rx_full;
    logic serial_tx_empty;
    logic sync_serial_done;
    logic capture_compare;
    logic timer_two_match;
    logic timer_one_overflow;
    logic osc_fail;
    logic comparator_two;
    logic comparator_one;
    logic nv_write_done;
  } src_evt_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Whole state of the top module
  typedef struct packed {
    logic [DATA_W-1:0] enable_1;
    logic [DATA_W-1:0] enable_2;
    logic [DATA_W-1:0] core_ctrl;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } ctrl_state_t;

endpackage

// file: flag_bank.sv
/*
  Sticky interrupt flag register of one peripheral group.
  Assumes set pulses and the write strobe are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module flag_bank import irq_enable_pkg::*; #(
  parameter logic [DATA_W-1:0] IMPL_MASK = 8'hff
) (
  input wire logic clk_sys,              // System clock
  input wire logic rstn,                 // Async reset, active low
  input wire logic [DATA_W-1:0] set,     // Event per bit
  input wire logic we,                   // Software write
  input wire logic [DATA_W-1:0] wdata,   // Software value
  output logic [DATA_W-1:0] flags        // Registered flags
);
  typedef struct packed {
    logic [DATA_W-1:0] flags;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.flags = wdata;
    end
    // Event wins over a same-cycle clear, no enable involved
    s_d.flags = (s_d.flags | set) & IMPL_MASK;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{flags: FLAGS_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;
endmodule

// file: masked_any.sv
/*
  Combinational gate of one group: flags ANDed with enables and implemented bits.
  Assumes both inputs come straight from registers.
*/
`timescale 1ns/100ps
module masked_any import irq_enable_pkg::*; #(
  parameter logic [DATA_W-1:0] IMPL_MASK = 8'hff
) (
  input wire logic [DATA_W-1:0] flags,   // Group flags
  input wire logic [DATA_W-1:0] enable,  // Group enables
  output logic [DATA_W-1:0] pend,        // Enabled and set
  output logic any                       // Some bit pending
);
  assign pend = flags & enable & IMPL_MASK;
  assign any = |pend;
endmodule

// file: peripheral_irq_enable_mask.sv
/*
  Peripheral interrupt enable and mask block: two enable registers, two sticky
  flag groups, the core enable pair and the forwarded peripheral request.
  Assumes a synchronous register master on clk_sys that never needs a wait.
*/
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
module peripheral_irq_enable_mask import irq_enable_pkg::*; (
  input wire logic clk_sys,              // 20 MHz system clock
  input wire logic rstn,                 // Async reset, active low
  input wire logic [ADDR_W-1:0] addr,    // Register index
  input wire logic [DATA_W-1:0] wdata,   // Write data
  input wire logic wr,                   // Write strobe
  input wire logic rd,                   // Read strobe
  output logic [DATA_W-1:0] rdata,       // Read data, cycle after rd
  input wire src_evt_t events,           // Peripheral event levels
  output logic irq_req,                  // Peripheral request to core
  output logic global_irq_enable         // Core-wide enable to core
);
  ctrl_state_t s_q;
  ctrl_state_t s_d;
  reg_req_t req;

  logic [DATA_W-1:0] set_1;
  logic [DATA_W-1:0] set_2;
  logic [DATA_W-1:0] flags_1;
  logic [DATA_W-1:0] flags_2;
  logic [DATA_W-1:0] pend_1;
  logic [DATA_W-1:0] pend_2;
  logic any_1;
  logic any_2;
  logic we_flags_1;
  logic we_flags_2;
  logic peripheral_group_enable;
  logic request_now;

  function automatic logic [DATA_W-1:0] masked_write(input logic [DATA_W-1:0] value,
                                                     input logic [DATA_W-1:0] mask);
    masked_write = value & mask;
  endfunction

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Map events into register layout
  always_comb begin
    set_1 = '0;
    set_2 = '0;
    set_1[CONV_DONE_BIT] = events.conv_done;
    set_1[SERIAL_RX_FULL_BIT] = events.serial_rx_full;
    set_1[SERIAL_TX_EMPTY_BIT] = events.serial_tx_empty;
    set_1[SYNC_SERIAL_DONE_BIT] = events.sync_serial_done;
    set_1[CAPTURE_COMPARE_BIT] = events.capture_compare;
    set_1[TIMER_TWO_MATCH_BIT] = events.timer_two_match;
    set_1[TIMER_ONE_OVERFLOW_BIT] = events.timer_one_overflow;
    set_2[OSC_FAIL_BIT] = events.osc_fail;
    set_2[COMPARATOR_TWO_BIT] = events.comparator_two;
    set_2[COMPARATOR_ONE_BIT] = events.comparator_one;
    set_2[NV_WRITE_DONE_BIT] = events.nv_write_done;
  end

  assign we_flags_1 = hit(req, OFS_FLAGS_1);
  assign we_flags_2 = hit(req, OFS_FLAGS_2);

  flag_bank #(
    .IMPL_MASK(GROUP_1_IMPL_MASK)
  ) u_flags_1 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .set(set_1),
    .we(we_flags_1),
    .wdata(wdata),
    .flags(flags_1)
  );

  flag_bank #(
    .IMPL_MASK(GROUP_2_IMPL_MASK)
  ) u_flags_2 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .set(set_2),
    .we(we_flags_2),
    .wdata(wdata),
    .flags(flags_2)
  );

  // Per-source gating, bit positions fixed by the group masks
  masked_any #(
    .IMPL_MASK(GROUP_1_IMPL_MASK)
  ) u_gate_1 (
    .flags(flags_1),
    .enable(s_q.enable_1),
    .pend(pend_1),
    .any(any_1)
  );

  masked_any #(
    .IMPL_MASK(GROUP_2_IMPL_MASK)
  ) u_gate_2 (
    .flags(flags_2),
    .enable(s_q.enable_2),
    .pend(pend_2),
    .any(any_2)
  );

  assign peripheral_group_enable = s_q.core_ctrl[PERIPHERAL_GROUP_ENABLE_BIT];
  assign global_irq_enable = s_q.core_ctrl[GLOBAL_IRQ_ENABLE_BIT];

  // Both core enables gate the OR of the groups
  assign request_now = (any_1 || any_2) && peripheral_group_enable && global_irq_enable;

  always_comb begin
    s_d = s_q;
    if (hit(req, OFS_ENABLE_1)) begin
      s_d.enable_1 = masked_write(req.wdata, GROUP_1_IMPL_MASK);
    end
    if (hit(req, OFS_ENABLE_2)) begin
      s_d.enable_2 = masked_write(req.wdata, GROUP_2_IMPL_MASK);
    end
    if (hit(req, OFS_CORE_CTRL)) begin
      s_d.core_ctrl = masked_write(req.wdata, CORE_CTRL_IMPL_MASK);
    end
    // Read data valid only in the cycle after rd; zero otherwise
    s_d.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        OFS_ENABLE_1: begin
          s_d.rdata = s_q.enable_1;
        end
        OFS_ENABLE_2: begin
          s_d.rdata = s_q.enable_2;
        end
        OFS_FLAGS_1: begin
          s_d.rdata = flags_1;
        end
        OFS_FLAGS_2: begin
          s_d.rdata = flags_2;
        end
        OFS_CORE_CTRL: begin
          s_d.rdata = s_q.core_ctrl;
        end
        OFS_PENDING: begin
          s_d.rdata[PEND_GROUP_1_BIT] = any_1;
          s_d.rdata[PEND_GROUP_2_BIT] = any_2;
          s_d.rdata[PEND_REQUEST_BIT] = s_q.irq;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
    // Registered so the core sees a glitch-free level
    s_d.irq = request_now;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{enable_1: ENABLE_1_RST, enable_2: ENABLE_2_RST, core_ctrl: CORE_CTRL_RST,
               rdata: '0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq_req = s_q.irq;

  // Checks

  AST_GROUP_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !peripheral_group_enable |=> !irq_req)
    else $error("request passed with peripheral group disabled");

  AST_GLOBAL_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !global_irq_enable |=> !irq_req)
    else $error("request passed with global enable clear");

  AST_GROUP_OPEN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (peripheral_group_enable && global_irq_enable && (|(flags_1 & s_q.enable_1))) |=> irq_req)
    else $error("unmasked peripheral request was suppressed");

  AST_CONV_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (flags_1[CONV_DONE_BIT] && !s_q.enable_1[CONV_DONE_BIT]) |-> !pend_1[CONV_DONE_BIT])
    else $error("conversion interrupt passed while disabled");

  AST_RX_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    pend_1[SERIAL_RX_FULL_BIT] == (flags_1[SERIAL_RX_FULL_BIT] && s_q.enable_1[SERIAL_RX_FULL_BIT]))
    else $error("receive gate mismatch");

  AST_TX_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (flags_1 == 8'h10 && flags_2 == 8'h00 && s_q.enable_1[SERIAL_TX_EMPTY_BIT]
     && peripheral_group_enable && global_irq_enable)
    |=> irq_req)
    else $error("transmit interrupt not forwarded");

  AST_SYNC_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (flags_1 == 8'h08 && flags_2 == 8'h00 && !s_q.enable_1[SYNC_SERIAL_DONE_BIT]) |-> !request_now)
    else $error("sync serial interrupt passed while disabled");

  AST_CAPCMP_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    pend_1[CAPTURE_COMPARE_BIT] |-> s_q.enable_1[CAPTURE_COMPARE_BIT])
    else $error("capture/compare interrupt passed while disabled");

  AST_TIMERS_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    pend_1[1:0] == (flags_1[1:0] & s_q.enable_1[1:0]))
    else $error("timer gate mismatch");

  AST_GROUP_2_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    pend_2 == (flags_2 & s_q.enable_2 & 8'hf0))
    else $error("group two gate mismatch");

  AST_FLAG_SETS: assert property (@(posedge clk_sys) disable iff (!rstn)
    events.osc_fail |=> flags_2[OSC_FAIL_BIT])
    else $error("flag missed its event");

  AST_FLAG_SET_WINS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (events.timer_one_overflow && we_flags_1 && !wdata[0]) |=> flags_1[TIMER_ONE_OVERFLOW_BIT])
    else $error("clear beat a same-cycle event");

  AST_UNIMPL_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_q.enable_1[7] == 1'b0) && (s_q.enable_2[3:0] == 4'h0))
    else $error("unimplemented enable bit set");

  AST_ENABLE_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    hit(req, OFS_ENABLE_2) |=> s_q.enable_2 == ($past(wdata) & 8'hf0))
    else $error("enable register two did not take write");

  AST_REQUEST_FORM: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq_req == $past(|((flags_1 & s_q.enable_1) | (flags_2 & s_q.enable_2))
                     && peripheral_group_enable && global_irq_enable))
    else $error("request does not follow flags and enables");

  AST_READ_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rd |=> rdata == 8'h00)
    else $error("read data outside the read answer cycle");

endmodule

// file: periph_core_model.sv
/*
  Behavioural far side of the interrupt enable block: the peripherals, which raise
  event levels when the bench commands them.
  Assumes the bench drives fire by non-blocking assignment at a rising clk_sys edge.
*/
`timescale 1ns/100ps
module periph_core_model import irq_enable_pkg::*; (
  input wire logic clk_sys,      // System clock
  input wire logic rstn,         // Async reset, active low
  input wire logic [10:0] fire,  // Events to raise, one bit per source
  output src_evt_t events        // Event levels to the block
);
  // Registered so events move just after an edge, as real peripherals do
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      events <= '0;
    end else begin
      events <= src_evt_t'(fire);
    end
  end
endmodule

// file: testbench.sv
/*
  Self-checking bench for the peripheral interrupt enable block: register access,
  per-source gating, core enables and random traffic.
  Assumes the far-side model in periph_core_model and the shared package.
*/
`timescale 1ns/100ps
module testbench import irq_enable_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [10:0] fire = '0;
  logic [DATA_W-1:0] rdata;
  src_evt_t events;
  logic irq_req;
  logic global_irq_enable;
  int mismatches = 0;
  int n_checks = 0;

  always #25 clk_sys = ~clk_sys;

  peripheral_irq_enable_mask dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .events(events), .irq_req(irq_req), .global_irq_enable(global_irq_enable));
  periph_core_model far_side (.clk_sys(clk_sys), .rstn(rstn), .fire(fire), .events(events));

  // Event vector to flag group layout
  function automatic logic [7:0] f1(input logic [10:0] e);
    return {1'b0, e[10:4]};
  endfunction
  function automatic logic [7:0] f2(input logic [10:0] e);
    return {e[3:0], 4'h0};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Flags cleared before any enable is set, so no stale request appears
  task automatic setup(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] cc);
    wr_reg(OFS_FLAGS_1, 8'h00);
    wr_reg(OFS_FLAGS_2, 8'h00);
    wr_reg(OFS_ENABLE_1, e1);
    wr_reg(OFS_ENABLE_2, e2);
    wr_reg(OFS_CORE_CTRL, cc);
  endtask

  // Request must show exactly one edge after the flags sample the event, not at that edge
  task automatic fire_evt(input logic [10:0] ev, input logic exp);
    @(posedge clk_sys);
    fire <= ev;
    @(posedge clk_sys);
    fire <= '0;
    @(posedge clk_sys);
    #1 check("irq_req early", {7'h0, irq_req}, 8'h00);
    @(posedge clk_sys);
    #1 check("irq_req", {7'h0, irq_req}, {7'h0, exp});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    results();
  end

  initial begin
    logic [7:0] v;
    logic [10:0] ev;
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] cc;
    logic req;
    void'($urandom(93));
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], v);
      check("reset value", v, 8'h00);
    end
    wr_reg(OFS_ENABLE_1, 8'hff);
    rd_reg(OFS_ENABLE_1, v);
    check("enable_1 bits", v, 8'h7f);
    wr_reg(OFS_ENABLE_2, 8'hff);
    rd_reg(OFS_ENABLE_2, v);
    check("enable_2 bits", v, 8'hf0);
    wr_reg(OFS_CORE_CTRL, 8'hff);
    rd_reg(OFS_CORE_CTRL, v);
    check("core_ctrl bits", v, 8'hc0);
    wr_reg(3'h6, 8'hff);
    rd_reg(3'h6, v);
    check("unmapped", v, 8'h00);
    // Each source alone: enabled it requests, masked it only flags
    for (int i = 0; i < 11; i++) begin
      ev = 11'h1 << i;
      setup(f1(ev), f2(ev), 8'hc0);
      fire_evt(ev, 1'b1);
      setup(~f1(ev), ~f2(ev), 8'hc0);
      fire_evt(ev, 1'b0);
      rd_reg(OFS_FLAGS_1, v);
      check("flags_1 masked", v, f1(ev));
      rd_reg(OFS_FLAGS_2, v);
      check("flags_2 masked", v, f2(ev));
    end
    // Core enable pair, every combination
    for (int k = 0; k < 4; k++) begin
      cc = {k[1:0], 6'h00};
      setup(8'hff, 8'hff, cc);
      fire_evt(11'h7ff, cc[7] & cc[6]);
      check("global enable", {7'h0, global_irq_enable}, {7'h0, cc[7]});
    end
    // Random traffic
    for (int n = 0; n < 30; n++) begin
      ev = 11'($urandom);
      e1 = 8'($urandom);
      e2 = 8'($urandom);
      cc = (n < 4) ? 8'hc0 : 8'($urandom);
      req = (|((f1(ev) & e1) | (f2(ev) & e2))) & cc[7] & cc[6];
      setup(e1, e2, cc);
      fire_evt(ev, req);
      rd_reg(OFS_FLAGS_1, v);
      check("flags_1", v, f1(ev));
      rd_reg(OFS_FLAGS_2, v);
      check("flags_2", v, f2(ev));
      rd_reg(OFS_PENDING, v);
      check("pending", v, {5'h0, req, |(f2(ev) & e2), |(f1(ev) & e1)});
    end
    // Event lands in the very cycle software clears its flag: the event must win
    setup(8'h01, 8'h00, 8'hc0);
    @(posedge clk_sys);
    fire <= 11'h010;
    @(posedge clk_sys);
    fire <= '0;
    addr <= OFS_FLAGS_1;
    wdata <= 8'h00;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd_reg(OFS_FLAGS_1, v);
    check("flag set wins", v, 8'h01);
    check("irq_req after set wins", {7'h0, irq_req}, 8'h01);
    wr_reg(OFS_FLAGS_1, 8'h00);
    @(posedge clk_sys);
    #1 check("irq_req after clear", {7'h0, irq_req}, 8'h00);
    // Reset in mid-run clears everything
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("irq_req in reset", {7'h0, irq_req}, 8'h00);
    check("global in reset", {7'h0, global_irq_enable}, 8'h00);
    @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(OFS_ENABLE_2, v);
    check("enable_2 after reset", v, 8'h00);
    results();
  end
endmodule
